// File: core/mbc_pkg.sv
// Package of register offsets, field layouts and codes for the bias and channel 1 config bank.
package mbc_pkg;
  localparam logic [7:0] BIAS_FS_OFFSET = 8'h3b;
  localparam logic [7:0] CH1_IN_OFFSET = 8'h3c;
  localparam logic [7:0] BIAS_FS_RESET = 8'h00;
  localparam logic [7:0] CH1_IN_RESET = 8'h00;
  localparam logic [7:0] BIAS_FS_WMASK = 8'h73;
  localparam logic [7:0] CH1_IN_WMASK = 8'hfd;
  localparam int BIAS_LSB = 4;
  localparam int FS_LSB = 0;
  localparam int TYPE_BIT = 7;
  localparam int SRC_LSB = 5;
  localparam int COUPLE_BIT = 4;
  localparam int IMP_LSB = 2;
  localparam int RGE_BIT = 0;
  localparam int RGM_SEL_BIT = 3;
  localparam logic [2:0] BIAS_VREF = 3'h0;
  localparam logic [2:0] BIAS_VREF_SCALED = 3'h1;
  localparam logic [2:0] BIAS_ANALOG_SUPPLY = 3'h6;
  localparam logic [1:0] FS_2V75 = 2'h0;
  localparam logic [1:0] FS_2V5 = 2'h1;
  localparam logic [1:0] FS_1V375 = 2'h2;
  localparam logic [1:0] SRC_DIFF = 2'h0;
  localparam logic [1:0] SRC_SINGLE = 2'h1;
  localparam logic [1:0] SRC_DENSITY = 2'h2;
  localparam logic [1:0] IMP_2K5 = 2'h0;
  localparam logic [1:0] IMP_10K = 2'h1;
  localparam logic [1:0] IMP_20K = 2'h2;
endpackage

// File: core/mbc_decode.sv
// Field decoder that turns the stored register bytes into one-hot analog steering controls.
`timescale 1ns/100ps
module mbc_decode (
  input wire logic [7:0] bias_reg_i, // Stored bias and full-scale byte
  input wire logic [7:0] ch1_reg_i, // Stored channel 1 input byte
  input wire logic range_gain_mode_i, // Range or gain selector from the mode register
  output logic [2:0] bias_sel_o, // One-hot: reference, scaled reference, analog supply
  output logic [2:0] fs_sel_o, // One-hot: 2.75 V, 2.5 V, 1.375 V
  output logic [2:0] src_sel_o, // One-hot: differential, single-ended, density
  output logic [2:0] imp_sel_o, // One-hot: 2.5k, 10k, 20k
  output logic dc_couple_o, // DC coupling applied to the analog path
  output logic range_enh_o, // Range enhancer active
  output logic auto_gain_o // Automatic gain active
);
  wire logic [2:0] bias_code = bias_reg_i[mbc_pkg::BIAS_LSB +: 3];
  wire logic [1:0] fs_code = bias_reg_i[mbc_pkg::FS_LSB +: 2];
  wire logic [1:0] src_code = ch1_reg_i[mbc_pkg::SRC_LSB +: 2];
  wire logic [1:0] imp_code = ch1_reg_i[mbc_pkg::IMP_LSB +: 2];
  wire logic analog_src = (src_code == mbc_pkg::SRC_DIFF) || (src_code == mbc_pkg::SRC_SINGLE);
  wire logic rge_on = ch1_reg_i[mbc_pkg::RGE_BIT];

  // Reserved codes leave every select of their group low.
  assign bias_sel_o = {bias_code == mbc_pkg::BIAS_ANALOG_SUPPLY,
                       bias_code == mbc_pkg::BIAS_VREF_SCALED,
                       bias_code == mbc_pkg::BIAS_VREF};
  assign fs_sel_o = {fs_code == mbc_pkg::FS_1V375,
                     fs_code == mbc_pkg::FS_2V5,
                     fs_code == mbc_pkg::FS_2V75};
  assign src_sel_o = {src_code == mbc_pkg::SRC_DENSITY,
                      src_code == mbc_pkg::SRC_SINGLE,
                      src_code == mbc_pkg::SRC_DIFF};
  // Coupling and impedance only steer an analog source.
  assign imp_sel_o = analog_src ? {imp_code == mbc_pkg::IMP_20K,
                                   imp_code == mbc_pkg::IMP_10K,
                                   imp_code == mbc_pkg::IMP_2K5} : 3'h0;
  assign dc_couple_o = analog_src && ch1_reg_i[mbc_pkg::COUPLE_BIT];
  assign range_enh_o = rge_on && !range_gain_mode_i;
  assign auto_gain_o = rge_on && range_gain_mode_i;
endmodule

// File: core/mbc_bank.sv
// Register bank holding the microphone bias, full-scale and channel 1 input settings.
`timescale 1ns/100ps
module mbc_bank (
  input wire logic ref_clk_i, // Control clock, 20 MHz
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic [7:0] page_i, // Current register page
  input wire logic [7:0] addr_i, // Register address within the page
  input wire logic wr_en_i, // Write strobe, one cycle
  input wire logic [7:0] wr_data_i, // Write data
  input wire logic rd_en_i, // Read strobe, one cycle
  input wire logic [7:0] range_gain_mode_reg_i, // Mode register byte from elsewhere
  output logic [7:0] rd_data_o, // Read data, valid the cycle after rd_en_i
  output logic rd_valid_o, // Read data valid pulse
  output logic [2:0] bias_level_select_o, // One-hot bias source
  output logic [2:0] converter_full_scale_select_o, // One-hot full-scale reference
  output logic ch_one_input_type_o, // 0 microphone, 1 line
  output logic [2:0] ch_one_source_select_o, // One-hot input source
  output logic ch_one_coupling_select_o, // DC coupling active
  output logic [2:0] ch_one_impedance_select_o, // One-hot input impedance
  output logic range_enhancer_o, // Range enhancer enable
  output logic auto_gain_control_o // Automatic gain enable
);
  logic [7:0] bias_reg;
  logic [7:0] ch1_reg;
  logic [2:0] bias_sel;
  logic [2:0] fs_sel;
  logic [2:0] src_sel;
  logic [2:0] imp_sel;
  logic dc_couple;
  logic range_enh;
  logic auto_gain;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic page_zero = (page_i == 8'h00);
  wire logic hit_bias = page_zero && (addr_i == mbc_pkg::BIAS_FS_OFFSET);
  wire logic hit_ch1 = page_zero && (addr_i == mbc_pkg::CH1_IN_OFFSET);
  wire logic [7:0] next_bias = wr_data_i & mbc_pkg::BIAS_FS_WMASK;
  wire logic [7:0] next_ch1 = wr_data_i & mbc_pkg::CH1_IN_WMASK;
  wire logic [7:0] next_rd_data = hit_bias ? bias_reg : (hit_ch1 ? ch1_reg : 8'h00);
  wire logic gain_mode_bit = range_gain_mode_reg_i[mbc_pkg::RGM_SEL_BIT];
  wire logic range_gain_on = ch1_reg[mbc_pkg::RGE_BIT];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bias_reg <= mbc_pkg::BIAS_FS_RESET;
    end else if (wr_en_i && hit_bias) begin
      bias_reg <= next_bias;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ch1_reg <= mbc_pkg::CH1_IN_RESET;
    end else if (wr_en_i && hit_ch1) begin
      ch1_reg <= next_ch1;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // A read in the same cycle as a write to that register returns the value held before it.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_data_o <= rd_en_i ? next_rd_data : 8'h00;
      rd_valid_o <= rd_en_i;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  mbc_decode u_decode (
    .bias_reg_i(bias_reg),
    .ch1_reg_i(ch1_reg),
    .range_gain_mode_i(gain_mode_bit),
    .bias_sel_o(bias_sel),
    .fs_sel_o(fs_sel),
    .src_sel_o(src_sel),
    .imp_sel_o(imp_sel),
    .dc_couple_o(dc_couple),
    .range_enh_o(range_enh),
    .auto_gain_o(auto_gain)
  );

  // Outputs are registered so the analog controls change glitch-free.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bias_level_select_o <= 3'h0;
      converter_full_scale_select_o <= 3'h0;
      ch_one_input_type_o <= 1'b0;
      ch_one_source_select_o <= 3'h0;
      ch_one_coupling_select_o <= 1'b0;
      ch_one_impedance_select_o <= 3'h0;
      range_enhancer_o <= 1'b0;
      auto_gain_control_o <= 1'b0;
    end else begin
      bias_level_select_o <= bias_sel;
      converter_full_scale_select_o <= fs_sel;
      ch_one_input_type_o <= ch1_reg[mbc_pkg::TYPE_BIT];
      ch_one_source_select_o <= src_sel;
      ch_one_coupling_select_o <= dc_couple;
      ch_one_impedance_select_o <= imp_sel;
      range_enhancer_o <= range_enh;
      auto_gain_control_o <= auto_gain;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_write_bias;
    wr_en_i && hit_bias;
  endsequence

  sequence s_write_ch1;
    wr_en_i && hit_ch1;
  endsequence

  sequence s_bias_out(logic [2:0] code);
    ##2 (bias_level_select_o == {code == 3'h6, code == 3'h1, code == 3'h0});
  endsequence

  // Steering outputs lag a write by two edges: one to store the byte, one to register the decode.
  a_bias_level_out: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_write_bias |-> s_bias_out($past(wr_data_i[6:4], 2)))
    else $error("Bias level select does not follow the written code.");

  a_fullscale_out: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_en_i && hit_bias && wr_data_i[1:0] == 2'h3) |-> ##2 (converter_full_scale_select_o == 3'h0))
    else $error("Reserved full-scale code drives a reference.");

  a_input_type: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_en_i && hit_ch1) |-> ##2 (ch_one_input_type_o == $past(wr_data_i[7], 2)))
    else $error("Input type does not follow bit 7.");

  a_source_onehot: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_en_i && hit_ch1 && wr_data_i[6:5] == 2'h2) |-> ##2 (ch_one_source_select_o == 3'h4))
    else $error("Density source not selected.");

  a_coupling_analog: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ch_one_source_select_o[2] |-> !ch_one_coupling_select_o && ch_one_impedance_select_o == 3'h0)
    else $error("Coupling or impedance applied to a digital source.");

  a_impedance_out: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_en_i && hit_ch1 && wr_data_i[6:5] == 2'h0 && wr_data_i[3:2] == 2'h2)
    |-> ##2 (ch_one_impedance_select_o == 3'h4))
    else $error("20k impedance not selected.");

  a_range_enh_out: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !$past(srst_i) |-> (range_enhancer_o == ($past(range_gain_on) && !$past(gain_mode_bit))))
    else $error("Range enhancer enable does not follow bit 0 and the mode bit.");

  a_auto_gain_out: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !$past(srst_i) |-> (auto_gain_control_o == ($past(range_gain_on) && $past(gain_mode_bit))))
    else $error("Gain control enable does not follow bit 0 and the mode bit.");

  a_range_gain_excl: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !(range_enhancer_o && auto_gain_control_o))
    else $error("Enhancer and gain control enabled together.");

  a_reset_zero: assert property (@(posedge ref_clk_i)
    $past(srst_i) |-> (bias_reg == 8'h00))
    else $error("Bias register not zero after reset.");

  a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rd_en_i && !hit_bias && !hit_ch1) |=> (rd_valid_o && (rd_data_o == 8'h00)))
    else $error("Unmapped read returns non-zero data.");

  a_bias_read: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rd_en_i && hit_bias) |=> (rd_valid_o && (rd_data_o == $past(bias_reg))))
    else $error("Bias register read does not return the stored byte.");

  a_foreign_page: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_en_i && !page_zero) |=> ($stable(bias_reg) && $stable(ch1_reg)))
    else $error("Write outside page 0 changed a register.");

  a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rd_valid_o && $past(hit_bias)) |-> ((rd_data_o[7] == 1'b0) && (rd_data_o[3:2] == 2'h0)))
    else $error("Reserved bias bit reads non-zero.");

  a_reserved_ch1: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rd_valid_o && $past(hit_ch1)) |-> (rd_data_o[1] == 1'b0))
    else $error("Reserved channel 1 bit reads non-zero.");

  a_ch1_read: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rd_en_i && hit_ch1) |=> (rd_valid_o && (rd_data_o == $past(ch1_reg))))
    else $error("Channel 1 register read does not return the stored byte.");

  a_fullscale_map: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (s_write_bias ##0 (wr_data_i[1:0] == 2'h1))
    |-> ##2 (converter_full_scale_select_o == 3'h2))
    else $error("Full-scale code 1 does not select 2.5 V.");

  a_bias_supply: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (s_write_bias ##0 (wr_data_i[6:4] == 3'h6)) |-> ##2 (bias_level_select_o == 3'h4))
    else $error("Bias code 6 does not select the analog supply.");

  a_src_single: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (s_write_ch1 ##0 (wr_data_i[6:5] == 2'h1)) |-> ##2 (ch_one_source_select_o == 3'h2))
    else $error("Single-ended source not selected.");

  a_coupling_dc: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (s_write_ch1 ##0 (wr_data_i[6:4] == 3'h3)) |-> ##2 ch_one_coupling_select_o)
    else $error("DC coupling not applied to an analog source.");
endmodule

// File: tb/tb_mbc_bank.sv
// Self-checking bench for the bias, full-scale and channel 1 input register bank.
`timescale 1ns/100ps
module tb_mbc_bank;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] page_i = 8'h00;
  logic [7:0] addr_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic rd_en_i = 1'b0;
  logic [7:0] range_gain_mode_reg_i = 8'h00;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic [2:0] bias_o, fs_o, src_o, imp_o;
  logic type_o, dc_o, enh_o, gain_o;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] d;
  logic [2:0] e;
  logic an;
  logic m;
  always #25 ref_clk_i = ~ref_clk_i;
  mbc_bank i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .page_i(page_i), .addr_i(addr_i),
    .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
    .range_gain_mode_reg_i(range_gain_mode_reg_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .bias_level_select_o(bias_o),
    .converter_full_scale_select_o(fs_o), .ch_one_input_type_o(type_o),
    .ch_one_source_select_o(src_o), .ch_one_coupling_select_o(dc_o),
    .ch_one_impedance_select_o(imp_o), .range_enhancer_o(enh_o), .auto_gain_control_o(gain_o));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize();
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [2:0] oh(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : (3'h1 << c);
  endfunction
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    page_i <= pg;
    addr_i <= a;
    wr_data_i <= v;
    wr_en_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp, input bit w);
    @(posedge ref_clk_i);
    page_i <= pg;
    addr_i <= a;
    rd_en_i <= 1'b1;
    wr_en_i <= w;
    wr_data_i <= 8'hff;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    wr_en_i <= 1'b0;
    #1;
    chk("rd_valid", {7'h0, rd_valid_o}, 8'h01);
    chk("rd_data", rd_data_o, exp);
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rd(8'h00, mbc_pkg::BIAS_FS_OFFSET, mbc_pkg::BIAS_FS_RESET, 0);
    rd(8'h00, mbc_pkg::CH1_IN_OFFSET, mbc_pkg::CH1_IN_RESET, 0);
    chk("bias_reset", {5'h0, bias_o}, 8'h01);
    chk("src_reset", {5'h0, src_o}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      d = {1'b1, i[2:0], 2'h3, i[1:0]};
      e = (i == 0) ? 3'h1 : (i == 1) ? 3'h2 : (i == 6) ? 3'h4 : 3'h0;
      wr(8'h00, mbc_pkg::BIAS_FS_OFFSET, d);
      chk("bias_sel", {5'h0, bias_o}, {5'h0, e});
      chk("fs_sel", {5'h0, fs_o}, {5'h0, oh(i[1:0])});
      rd(8'h00, mbc_pkg::BIAS_FS_OFFSET, d & 8'h73, 0);
    end
    for (int i = 0; i < 16; i++) begin
      m = i[3];
      @(posedge ref_clk_i);
      range_gain_mode_reg_i <= m ? 8'h08 : 8'hf7;
      d = {i[0], i[1:0], i[3], i[3:2], 1'b1, i[2]};
      an = (i[1:0] < 2'h2);
      wr(8'h00, mbc_pkg::CH1_IN_OFFSET, d);
      chk("type", {7'h0, type_o}, {7'h0, i[0]});
      chk("src_sel", {5'h0, src_o}, {5'h0, oh(i[1:0])});
      chk("coupling", {7'h0, dc_o}, {7'h0, i[3] & an});
      chk("imp_sel", {5'h0, imp_o}, an ? {5'h0, oh(i[3:2])} : 8'h00);
      chk("enhancer", {7'h0, enh_o}, {7'h0, i[2] & ~m});
      chk("auto_gain", {7'h0, gain_o}, {7'h0, i[2] & m});
      rd(8'h00, mbc_pkg::CH1_IN_OFFSET, d & 8'hfd, 0);
    end
    wr(8'h01, mbc_pkg::CH1_IN_OFFSET, 8'h00);
    rd(8'h00, mbc_pkg::CH1_IN_OFFSET, d & 8'hfd, 0);
    rd(8'h01, mbc_pkg::BIAS_FS_OFFSET, 8'h00, 0);
    rd(8'h00, 8'h3d, 8'h00, 0);
    wr(8'h00, mbc_pkg::CH1_IN_OFFSET, 8'h22);
    rd(8'h00, mbc_pkg::CH1_IN_OFFSET, 8'h20, 1);
    rd(8'h00, mbc_pkg::CH1_IN_OFFSET, 8'hfd, 0);
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(8'h00, mbc_pkg::CH1_IN_OFFSET, mbc_pkg::CH1_IN_RESET, 0);
    rd(8'h00, mbc_pkg::BIAS_FS_OFFSET, mbc_pkg::BIAS_FS_RESET, 0);
    chk("gain_reset", {7'h0, gain_o}, 8'h00);
    chk("bias_after_reset", {5'h0, bias_o}, 8'h01);
    summarize();
  end
endmodule
